// ---- hw/psr_nvm.sv ----
`timescale 1ns/1ps
// nonvolatile image: one word per category plus marker pair
module psr_nvm #(
  parameter int NCAT = 6
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // step control
  input  wire logic              start,
  input  wire logic              erase,
  input  wire logic [NCAT-1:0]   cat_sel,
  input  wire logic [NCAT*32-1:0] live,
  input  wire logic [63:0]       mark_live,
  // results
  output logic                   busy,
  output logic [NCAT*32-1:0]     image,
  output logic [NCAT-1:0]        image_ok,
  output logic [63:0]            mark_image
);
  logic [15:0]        cnt_r, cnt_nxt;
  logic               busy_r, busy_nxt;
  logic               erase_r, erase_nxt;
  logic [NCAT-1:0]    sel_r, sel_nxt;
  logic [NCAT*32-1:0] img_r, img_nxt;
  logic [NCAT-1:0]    ok_r, ok_nxt;
  logic [63:0]        mk_r, mk_nxt;

  // nvm content does not reset: it survives reset and restart
  always_comb begin
    cnt_nxt   = cnt_r;
    busy_nxt  = busy_r;
    erase_nxt = erase_r;
    sel_nxt   = sel_r;
    img_nxt   = img_r;
    ok_nxt    = ok_r;
    mk_nxt    = mk_r;
    if (start && !busy_r) begin
      busy_nxt  = 1'b1;
      erase_nxt = erase;
      sel_nxt   = cat_sel;
      cnt_nxt   = 16'(psr_pkg::NVM_STEP_CYC);
    end else if (busy_r) begin
      if (cnt_r == 16'h0001) begin
        busy_nxt = 1'b0;
        // whole categories only
        for (int i = 0; i < NCAT; i++) begin
          if (sel_r[i]) begin
            img_nxt[i*32 +: 32] = erase_r ? 32'h0 : live[i*32 +: 32];
            ok_nxt[i]           = !erase_r;
          end
        end
        // marker stored with a full save
        if (!erase_r && &sel_r) mk_nxt = mark_live;
      end else begin
        cnt_nxt = cnt_r - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r   <= 16'h0;
      busy_r  <= 1'b0;
      erase_r <= 1'b0;
      sel_r   <= '0;
    end else begin
      cnt_r   <= cnt_nxt;
      busy_r  <= busy_nxt;
      erase_r <= erase_nxt;
      sel_r   <= sel_nxt;
    end
  end

  always_ff @(posedge clk) begin
    img_r <= img_nxt;
    ok_r  <= ok_nxt;
    mk_r  <= mk_nxt;
  end

  assign busy       = busy_r;
  assign image      = img_r;
  assign image_ok   = ok_r;
  assign mark_image = mk_r;
endmodule : psr_nvm

// ---- hw/psr_pkg.sv ----
// How it works
// - save word starts saving that category
// - finished save overwrites command with one
// - subindex 1..6: all,comm,appl,cust,drive,tuning
// - discard word erases that category
// - discard all spares tuning category
// - after erase the device restarts itself
// - tuning erased only by subindex six
// - marker takes date/time; saved by all
// - savable writes clear marker, except exemptions
// - stored objects reload at reset
// - whole categories only; uncategorised never stored
package psr_pkg;
  localparam logic [31:0] SAVE_WORD    = 32'h65766173;
  localparam logic [31:0] DISCARD_WORD = 32'h64616f6c;
  localparam logic [31:0] DONE_WORD    = 32'h00000001;
  localparam int          NUM_CAT      = 6;
  // register word addresses (byte address = 4 * index)
  localparam logic [5:0] ADR_SAVE_BASE = 6'h00; // 0x00..0x05 save sub 1..6
  localparam logic [5:0] ADR_DISC_BASE = 6'h08; // 0x08..0x0d discard sub 1..6
  localparam logic [5:0] ADR_MARK_DATE = 6'h10;
  localparam logic [5:0] ADR_MARK_TIME = 6'h11;
  localparam logic [5:0] ADR_OBJ_BASE  = 6'h18; // 0x18..0x1d savable object per category
  localparam logic [5:0] ADR_OBJ_NOCAT = 6'h1e; // uncategorised object
  localparam logic [5:0] ADR_STATUS    = 6'h20;
  localparam logic [5:0] ADR_MASK      = 6'h21;
  localparam logic [5:0] ADR_STATE     = 6'h22;
  // status bit positions
  localparam int ST_SAVE_DONE = 0;
  localparam int ST_DISC_DONE = 1;
  localparam int ST_REJECT    = 2;
  localparam int ST_RESTART   = 3;
  localparam logic [3:0] MASK_RST = 4'h0;
  // timing: one nvm step per save or discard, whatever the number of categories
  localparam int NVM_STEP_NS  = 1000;
  localparam int CLK_NS       = 20;
  localparam int NVM_STEP_CYC = (NVM_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESTART_CYC  = 4;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_LOAD = 3'b001, ST_SAVE = 3'b011,
    ST_ERASE = 3'b010, ST_DONE = 3'b110, ST_RESTART_S = 3'b111
  } psr_state_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  adr;
    logic [31:0] wdata;
  } psr_req_t;
endpackage : psr_pkg

// ---- hw/psr_top.sv ----
`timescale 1ns/1ps
module psr_top (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // avalon-mm slave
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic [1:0]       AVS_RESPONSE,
  // system
  output logic             IRQ,
  output logic             RESTART_REQ
);
  localparam int NC = psr_pkg::NUM_CAT;

  psr_pkg::psr_req_t   req;
  psr_pkg::psr_state_t st_r, st_nxt;
  logic               ack_r, ack_nxt;
  logic [31:0]        rdata_r, rdata_nxt;
  logic [1:0]         resp_r, resp_nxt;
  logic [NC*32-1:0]   cmd_r, cmd_nxt;      // save subindex words
  logic [NC*32-1:0]   dcmd_r, dcmd_nxt;    // discard subindex words
  logic [NC*32-1:0]   obj_r, obj_nxt;      // live savable objects
  logic [31:0]        nocat_r, nocat_nxt;
  logic [63:0]        mark_r, mark_nxt;
  logic [3:0]         stat_r, stat_nxt;
  logic [3:0]         mask_r, mask_nxt;
  logic [2:0]         sub_r, sub_nxt;      // subindex of running op
  logic               erase_r, erase_nxt;
  logic [3:0]         rcnt_r, rcnt_nxt;
  logic               nvm_start;
  logic               nvm_busy;
  logic [NC-1:0]      nvm_sel;
  logic [NC*32-1:0]   nvm_img;
  logic [NC-1:0]      nvm_ok;
  logic [63:0]        nvm_mark;
  logic [5:0]         widx;
  logic               acc;

  assign req.wr    = AVS_WRITE;
  assign req.rd    = AVS_READ;
  assign req.adr   = AVS_ADDRESS[7:2];
  assign req.wdata = AVS_WRITEDATA;
  assign acc       = (req.wr || req.rd) && !ack_r;
  assign widx      = req.adr;

  // categories touched by a subindex
  function automatic logic [NC-1:0] cat_mask(input logic [2:0] sub, input logic er);
    logic [NC-1:0] m;
    m = '0;
    // tuning sits in slot NC-2; slot NC-1 is spare and only a full save writes it
    if (sub == 3'd1) m = er ? {2'b00, {(NC-2){1'b1}}} : {NC{1'b1}};
    else if (sub >= 3'd2 && sub <= 3'd6) m[sub - 3'd2] = 1'b1;
    // subindex n>=2 is category n-2 in bit order comm..tuning
    return m;
  endfunction : cat_mask

  // bit i = subindex i+2 (comm..tuning); sub1 save covers all six slots, sub1 discard only the first four
  assign nvm_sel   = cat_mask(sub_r, erase_r);
  assign nvm_start = (st_r == psr_pkg::ST_SAVE) || (st_r == psr_pkg::ST_ERASE);

  psr_nvm #(.NCAT(NC - 1 + 1)) u_nvm (
    .clk        (CLK),
    .rstn       (RSTN),
    .start      (nvm_start),
    .erase      (erase_r),
    .cat_sel    (nvm_sel),
    .live       (obj_r),
    .mark_live  (mark_r),
    .busy       (nvm_busy),
    .image      (nvm_img),
    .image_ok   (nvm_ok),
    .mark_image (nvm_mark)
  );

  // bus, command and sequencing
  always_comb begin
    st_nxt    = st_r;
    ack_nxt   = 1'b0;
    rdata_nxt = rdata_r;
    resp_nxt  = 2'b00;
    cmd_nxt   = cmd_r;
    dcmd_nxt  = dcmd_r;
    obj_nxt   = obj_r;
    nocat_nxt = nocat_r;
    mark_nxt  = mark_r;
    stat_nxt  = stat_r;
    mask_nxt  = mask_r;
    sub_nxt   = sub_r;
    erase_nxt = erase_r;
    rcnt_nxt  = rcnt_r;
    unique case (st_r)
      psr_pkg::ST_LOAD: begin
        // reload stored objects after reset
        for (int i = 0; i < NC; i++)
          if (nvm_ok[i]) obj_nxt[i*32 +: 32] = nvm_img[i*32 +: 32];
        // spare slot valid means a full save stored the marker pair
        if (nvm_ok[NC-1]) mark_nxt = nvm_mark;
        st_nxt   = psr_pkg::ST_IDLE;
      end
      psr_pkg::ST_SAVE, psr_pkg::ST_ERASE: begin
        if (nvm_busy) st_nxt = psr_pkg::ST_DONE;
      end
      psr_pkg::ST_DONE: begin
        if (!nvm_busy) begin
          if (erase_r) begin
            stat_nxt[psr_pkg::ST_DISC_DONE] = 1'b1;
            stat_nxt[psr_pkg::ST_RESTART]   = 1'b1;
            rcnt_nxt = 4'(psr_pkg::RESTART_CYC);
            st_nxt   = psr_pkg::ST_RESTART_S;
          end else begin
            cmd_nxt[(32'(sub_r) - 1) * 32 +: 32] = psr_pkg::DONE_WORD;
            stat_nxt[psr_pkg::ST_SAVE_DONE] = 1'b1;
            st_nxt = psr_pkg::ST_IDLE;
          end
        end
      end
      psr_pkg::ST_RESTART_S: begin
        if (rcnt_r == 4'h1) st_nxt = psr_pkg::ST_LOAD;
        else rcnt_nxt = rcnt_r - 4'h1;
      end
      default: ;
    endcase
    if (acc) begin
      ack_nxt = 1'b1;
      if (req.rd) begin
        rdata_nxt = 32'h0;
        if (widx >= psr_pkg::ADR_SAVE_BASE && widx < psr_pkg::ADR_SAVE_BASE + 6'(NC))
          rdata_nxt = cmd_r[32'(widx - psr_pkg::ADR_SAVE_BASE) * 32 +: 32];
        else if (widx >= psr_pkg::ADR_DISC_BASE && widx < psr_pkg::ADR_DISC_BASE + 6'(NC))
          rdata_nxt = dcmd_r[32'(widx - psr_pkg::ADR_DISC_BASE) * 32 +: 32];
        else if (widx >= psr_pkg::ADR_OBJ_BASE && widx < psr_pkg::ADR_OBJ_BASE + 6'(NC))
          rdata_nxt = obj_r[32'(widx - psr_pkg::ADR_OBJ_BASE) * 32 +: 32];
        else if (widx == psr_pkg::ADR_OBJ_NOCAT) rdata_nxt = nocat_r;
        else if (widx == psr_pkg::ADR_MARK_DATE) rdata_nxt = mark_r[31:0];
        else if (widx == psr_pkg::ADR_MARK_TIME) rdata_nxt = mark_r[63:32];
        else if (widx == psr_pkg::ADR_STATUS) begin
          rdata_nxt = {28'h0, stat_r};
          stat_nxt  = 4'h0; // read clears
        end else if (widx == psr_pkg::ADR_MASK) rdata_nxt = {28'h0, mask_r};
        else if (widx == psr_pkg::ADR_STATE) rdata_nxt = {29'h0, st_r};
        else resp_nxt = 2'b10;
      end else begin
        if (widx >= psr_pkg::ADR_SAVE_BASE && widx < psr_pkg::ADR_SAVE_BASE + 6'(NC)) begin
          if (st_r != psr_pkg::ST_IDLE) begin
            stat_nxt[psr_pkg::ST_REJECT] = 1'b1;
          end else begin
            cmd_nxt[32'(widx - psr_pkg::ADR_SAVE_BASE) * 32 +: 32] = req.wdata;
            if (widx != psr_pkg::ADR_SAVE_BASE) mark_nxt = 64'h0;
            if (req.wdata == psr_pkg::SAVE_WORD) begin
              sub_nxt   = 3'(widx - psr_pkg::ADR_SAVE_BASE) + 3'd1;
              erase_nxt = 1'b0;
              st_nxt    = psr_pkg::ST_SAVE;
            end
          end
        end else if (widx >= psr_pkg::ADR_DISC_BASE
                     && widx < psr_pkg::ADR_DISC_BASE + 6'(NC)) begin
          if (st_r != psr_pkg::ST_IDLE) begin
            stat_nxt[psr_pkg::ST_REJECT] = 1'b1;
          end else begin
            dcmd_nxt[32'(widx - psr_pkg::ADR_DISC_BASE) * 32 +: 32] = req.wdata;
            if (req.wdata == psr_pkg::DISCARD_WORD) begin
              sub_nxt   = 3'(widx - psr_pkg::ADR_DISC_BASE) + 3'd1;
              erase_nxt = 1'b1;
              st_nxt    = psr_pkg::ST_ERASE;
            end
          end
        end else if (widx >= psr_pkg::ADR_OBJ_BASE
                     && widx < psr_pkg::ADR_OBJ_BASE + 6'(NC)) begin
          obj_nxt[32'(widx - psr_pkg::ADR_OBJ_BASE) * 32 +: 32] = req.wdata;
          mark_nxt = 64'h0;
        end else if (widx == psr_pkg::ADR_OBJ_NOCAT) nocat_nxt = req.wdata;
        else if (widx == psr_pkg::ADR_MARK_DATE) mark_nxt[31:0] = req.wdata;
        else if (widx == psr_pkg::ADR_MARK_TIME) mark_nxt[63:32] = req.wdata;
        else if (widx == psr_pkg::ADR_MASK) mask_nxt = req.wdata[3:0];
        else if (widx != psr_pkg::ADR_STATUS && widx != psr_pkg::ADR_STATE)
          resp_nxt = 2'b10;
      end
    end
    // events set after a clearing read: set wins
    if (st_r == psr_pkg::ST_DONE && !nvm_busy) begin
      if (erase_r) stat_nxt[psr_pkg::ST_DISC_DONE] = 1'b1;
      if (erase_r) stat_nxt[psr_pkg::ST_RESTART] = 1'b1;
      if (!erase_r) stat_nxt[psr_pkg::ST_SAVE_DONE] = 1'b1;
    end
    if (acc && req.wr && st_r != psr_pkg::ST_IDLE
        && ((widx < psr_pkg::ADR_SAVE_BASE + 6'(NC))
            || (widx >= psr_pkg::ADR_DISC_BASE && widx < psr_pkg::ADR_DISC_BASE + 6'(NC))))
      stat_nxt[psr_pkg::ST_REJECT] = 1'b1;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_r    <= psr_pkg::ST_LOAD;
      ack_r   <= 1'b0;
      rdata_r <= 32'h0;
      resp_r  <= 2'b00;
      cmd_r   <= '0;
      dcmd_r  <= '0;
      obj_r   <= '0;
      nocat_r <= 32'h0;
      mark_r  <= 64'h0;
      stat_r  <= 4'h0;
      mask_r  <= psr_pkg::MASK_RST;
      sub_r   <= 3'h0;
      erase_r <= 1'b0;
      rcnt_r  <= 4'h0;
    end else begin
      st_r    <= st_nxt;
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
      resp_r  <= resp_nxt;
      cmd_r   <= cmd_nxt;
      dcmd_r  <= dcmd_nxt;
      obj_r   <= obj_nxt;
      nocat_r <= nocat_nxt;
      mark_r  <= mark_nxt;
      stat_r  <= stat_nxt;
      mask_r  <= mask_nxt;
      sub_r   <= sub_nxt;
      erase_r <= erase_nxt;
      rcnt_r  <= rcnt_nxt;
    end
  end

  // answer one cycle after the request is seen
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_r;
  assign AVS_READDATA    = rdata_r;
  assign AVS_RESPONSE    = resp_r;
  assign IRQ             = |(stat_r & mask_r);
  assign RESTART_REQ     = (st_r == psr_pkg::ST_RESTART_S);

  property p_save_start;
    @(posedge CLK) disable iff (!RSTN)
      (acc && req.wr && st_r == psr_pkg::ST_IDLE && widx < 6'(NC)
       && req.wdata == psr_pkg::SAVE_WORD) |=> st_r == psr_pkg::ST_SAVE;
  endproperty
  a_save_start: assert property (p_save_start) else $error("save not started");

  property p_done_one;
    @(posedge CLK) disable iff (!RSTN)
      (st_r == psr_pkg::ST_DONE && !nvm_busy && !erase_r)
      |=> cmd_r[(32'(sub_r) - 1) * 32 +: 32] == psr_pkg::DONE_WORD;
  endproperty
  a_done_one: assert property (p_done_one) else $error("done word missing");

  property p_bad_word;
    @(posedge CLK) disable iff (!RSTN)
      (acc && req.wr && st_r == psr_pkg::ST_IDLE && req.wdata != psr_pkg::SAVE_WORD
       && req.wdata != psr_pkg::DISCARD_WORD) |=> st_r == psr_pkg::ST_IDLE;
  endproperty
  a_bad_word: assert property (p_bad_word) else $error("bad word started op");

  property p_busy_hold;
    @(posedge CLK) disable iff (!RSTN)
      (st_r == psr_pkg::ST_DONE && nvm_busy) |=> $stable(sub_r) && $stable(erase_r);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("op changed while busy");

  property p_tune_keep;
    @(posedge CLK) disable iff (!RSTN)
      (erase_r && sub_r == 3'd1) |-> !nvm_sel[NC-2];
  endproperty
  a_tune_keep: assert property (p_tune_keep) else $error("tuning erased by all");

  property p_tune_only6;
    @(posedge CLK) disable iff (!RSTN)
      (erase_r && nvm_sel[NC-2]) |-> sub_r == 3'd6;
  endproperty
  a_tune_only6: assert property (p_tune_only6) else $error("tuning erased wrongly");

  sequence s_erase_done;
    st_r == psr_pkg::ST_DONE && !nvm_busy && erase_r;
  endsequence
  property p_restart;
    @(posedge CLK) disable iff (!RSTN)
      s_erase_done |=> RESTART_REQ [*4] ##1 st_r == psr_pkg::ST_LOAD;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart after erase");

  property p_mark_clr;
    @(posedge CLK) disable iff (!RSTN)
      (acc && req.wr && widx >= psr_pkg::ADR_OBJ_BASE
       && widx < psr_pkg::ADR_OBJ_BASE + 6'(NC)) |=> mark_r == 64'h0;
  endproperty
  a_mark_clr: assert property (p_mark_clr) else $error("marker not cleared");

  property p_load;
    @(posedge CLK) disable iff (!RSTN)
      (st_r == psr_pkg::ST_LOAD && nvm_ok[NC-1]) |=> mark_r == $past(nvm_mark);
  endproperty
  a_load: assert property (p_load) else $error("marker not reloaded");
endmodule : psr_top

// ---- tb/psr_master_model.sv ----
`timescale 1ns/1ps
// register-bus master standing in for the fieldbus or configuration tool
module psr_master_model (
  // clock
  input  wire logic        clk,
  // slave answer
  input  wire logic        waitrequest,
  input  wire logic [31:0] readdata,
  input  wire logic [1:0]  response,
  // request
  output logic [7:0]       address,
  output logic             read,
  output logic             write,
  output logic [31:0]      writedata,
  output logic [3:0]       byteenable
);
  // idle bus at time zero; full-word lanes only
  initial begin
    address    = 8'h00;
    read       = 1'b0;
    write      = 1'b0;
    writedata  = 32'h00000000;
    byteenable = 4'hf;
  end

  // one transfer; request held until waitrequest is seen low at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] r, output logic ok);
    int n;
    n = 0;
    @(posedge clk);
    write     <= w;
    read      <= ~w;
    address   <= a;
    writedata <= d;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    q  = readdata;
    r  = response;
    ok = (n < 100);
    read  <= 1'b0;
    write <= 1'b0;
  endtask : xfer

  // poll a save subindex until it reads one
  task automatic wait_done(input logic [7:0] a, output logic ok);
    logic [31:0] q;
    logic [1:0]  r;
    logic        g;
    int          n;
    n = 0;
    q = 32'h00000000;
    g = 1'b1;
    while (q !== psr_pkg::DONE_WORD && n < 200 && g === 1'b1) begin
      xfer(1'b0, a, 32'h00000000, q, r, g);
      n++;
    end
    ok = (g === 1'b1) && (q === psr_pkg::DONE_WORD);
  endtask : wait_done
endmodule : psr_master_model

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
  // dut and bus wiring
  logic        CLK;
  logic        RSTN;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [1:0]  response;
  logic        IRQ;
  logic        RESTART_REQ;
  // bench state
  int          fail_count;
  int          comparisons;
  int          i;
  logic [31:0] q;
  logic [1:0]  r;
  logic        ok;

  psr_top u_psr_top (.CLK(CLK), .RSTN(RSTN), .AVS_ADDRESS(address), .AVS_READ(read),
    .AVS_WRITE(write), .AVS_WRITEDATA(writedata), .AVS_BYTEENABLE(byteenable),
    .AVS_READDATA(readdata), .AVS_WAITREQUEST(waitrequest), .AVS_RESPONSE(response),
    .IRQ(IRQ), .RESTART_REQ(RESTART_REQ));

  psr_master_model u_psr_master_model (.clk(CLK), .waitrequest(waitrequest),
    .readdata(readdata), .response(response), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable));

  // verdict and end of run
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // compare tasks, one per kind of result
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk32

  task automatic chk2(input logic [1:0] g, input logic [1:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk2

  task automatic chk1(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk1

  // bus access; a hung transfer ends the run
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    u_psr_master_model.xfer(w, a, d, q, r, ok);
    if (ok !== 1'b1) begin
      chk1(ok, 1'b1);
      end_sim();
    end
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk32(q, e);
  endtask : rd_chk

  task automatic set_mark(input logic [31:0] d, input logic [31:0] t);
    bus(1'b1, 8'h40, d);
    bus(1'b1, 8'h44, t);
  endtask : set_mark

  task automatic mk(input logic [31:0] d, input logic [31:0] t);
    rd_chk(8'h40, d);
    rd_chk(8'h44, t);
  endtask : mk

  task automatic done(input logic [7:0] a);
    u_psr_master_model.wait_done(a, ok);
    chk1(ok, 1'b1);
  endtask : done

  // restart pulse must come unprompted and last four cycles
  task automatic wait_restart();
    int n;
    n = 0;
    while (RESTART_REQ !== 1'b1 && n < 1000) begin
      @(posedge CLK);
      n++;
    end
    chk1(RESTART_REQ, 1'b1);
    n = 0;
    while (RESTART_REQ === 1'b1 && n < 20) begin
      @(posedge CLK);
      n++;
    end
    chk32(32'(n), 32'h00000004);
    n = 0;
    q = 32'hffffffff;
    while (q[2:0] !== psr_pkg::ST_IDLE && n < 20) begin
      bus(1'b0, 8'h88, 32'h00000000);
      n++;
    end
    chk32(q, {29'h0, psr_pkg::ST_IDLE});
  endtask : wait_restart

  // 50 MHz clock
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge CLK);
    fail_count++;
    end_sim();
  end

  // main sequence
  initial begin
    RSTN        = 1'b0;
    fail_count  = 0;
    comparisons = 0;
    repeat (20) @(posedge CLK);
    RSTN <= 1'b1;
    chk1(IRQ, 1'b0);
    chk1(RESTART_REQ, 1'b0);
    rd_chk(8'h84, {28'h0, psr_pkg::MASK_RST});
    rd_chk(8'h80, 32'h00000000);
    bus(1'b0, 8'hfc, 32'h00000000);
    chk2(r, 2'b10);
    // marker holds master values; savable writes and save-word writes to subindex 2..6 clear it
    set_mark(32'h20240101, 32'h00123456);
    mk(32'h20240101, 32'h00123456);
    bus(1'b1, 8'h78, 32'h0000aaaa);
    mk(32'h20240101, 32'h00123456);
    bus(1'b1, 8'h60, 32'h0000b00b);
    chk2(r, 2'b00);
    mk(32'h00000000, 32'h00000000);
    bus(1'b1, 8'h70, 32'h0000a11a);
    set_mark(32'h20240101, 32'h00123456);
    bus(1'b1, 8'h00, psr_pkg::SAVE_WORD);
    done(8'h00);
    mk(32'h20240101, 32'h00123456);
    // remaining save subindices, interrupt masked
    bus(1'b1, 8'h84, 32'h00000000);
    for (i = 1; i < 6; i++) begin
      set_mark(32'h20240202, 32'h00654321);
      bus(1'b1, 8'(i * 4), psr_pkg::SAVE_WORD);
      done(8'(i * 4));
      chk1(IRQ, 1'b0);
      rd_chk(8'h80, 32'h00000001);
      mk(32'h00000000, 32'h00000000);
    end
    // unmasked save-done raises the line; status read drops it
    bus(1'b1, 8'h84, 32'h00000001);
    bus(1'b1, 8'h04, psr_pkg::SAVE_WORD);
    done(8'h04);
    chk1(IRQ, 1'b1);
    rd_chk(8'h80, 32'h00000001);
    i = 0;
    while (IRQ !== 1'b0 && i < 5) begin
      @(posedge CLK);
      i++;
    end
    chk1(IRQ, 1'b0);
    // second command while saving is refused
    bus(1'b1, 8'h84, 32'h00000000);
    bus(1'b1, 8'h04, psr_pkg::SAVE_WORD);
    bus(1'b1, 8'h08, psr_pkg::SAVE_WORD);
    done(8'h04);
    rd_chk(8'h80, 32'h00000005);
    // wrong words start nothing
    bus(1'b1, 8'h0c, 32'h12345678);
    bus(1'b1, 8'h24, psr_pkg::SAVE_WORD);
    rd_chk(8'h88, {29'h0, psr_pkg::ST_IDLE});
    chk1(RESTART_REQ, 1'b0);
    rd_chk(8'h80, 32'h00000000);
    // discard all: tuning survives and reloads, others keep live values
    bus(1'b1, 8'h60, 32'h0000c00c);
    bus(1'b1, 8'h70, 32'h0000d00d);
    bus(1'b1, 8'h78, 32'h0000bbbb);
    bus(1'b1, 8'h20, psr_pkg::DISCARD_WORD);
    wait_restart();
    rd_chk(8'h80, 32'h0000000a);
    rd_chk(8'h60, 32'h0000c00c);
    rd_chk(8'h70, 32'h0000a11a);
    rd_chk(8'h78, 32'h0000bbbb);
    mk(32'h20240101, 32'h00123456);
    // single-category discards
    for (i = 1; i < 5; i++) begin
      bus(1'b1, 8'(32 + i * 4), psr_pkg::DISCARD_WORD);
      wait_restart();
    end
    // tuning erased only through its own subindex
    bus(1'b1, 8'h70, 32'h0000e00e);
    bus(1'b1, 8'h34, psr_pkg::DISCARD_WORD);
    wait_restart();
    rd_chk(8'h70, 32'h0000e00e);
    end_sim();
  end
endmodule : tb
